/* mpb_flow.sv */
`timescale 1ns/10ps
`default_nettype none
// Summary of operation
// - Flow control only with enable bit set
// - Pause unit is 512 bit times, 16 bits
// - Received pause frame holds off transmission
// - Pause starts after current frame ends
// - Control frames still forwarded on receive
// - Full duplex high mark sends pause time
// - Full duplex below low mark sends zero
// - Rearm only after low then high
// - Half duplex: wait receive start, then jam
// - Jam only at start of received frame
// - High mark arms qualified jamming; timer counts while jamming
// - Timer expiry lets exactly one frame in
// - Still above low mark: restart timer
// - Below low mark: reset timer, disarm
// - Low all ones, high zero: forced
// - Both speeds, both duplex modes
// - Back to back minimum frames sustained
// - Collision handling only in half duplex
// - Indirect phy register access via management

// Flow control for a 10/100 MAC: pause frames in full duplex,
// collision back pressure in half duplex, both steered by the receive
// fill marks, plus a serial management shifter for phy registers.
// Register bus: write and read strobes are one cycle; read data stand
// only in the cycle after the read and are zero otherwise.

module mpb_flow (
  input  wire logic        I_SYS_CLK,
  input  wire logic        I_RST_N,
  input  wire logic        I_CE,
  // Register bus
  input  wire logic [7:0]  I_ADDR,
  input  wire logic [31:0] I_WDATA,
  input  wire logic        I_WR,
  input  wire logic        I_RD,
  output logic      [31:0] O_RDATA,
  // Receive side status from the framer
  input  wire logic [7:0]  I_RX_FILL,
  input  wire logic        I_RX_SOF,
  input  wire logic        I_RX_EOF,
  input  wire logic        I_RX_ADDR_MATCH,
  input  wire logic        I_RX_MCAST,
  input  wire logic        I_RX_BCAST,
  input  wire logic        I_RX_PAUSE_VLD,
  input  wire logic [15:0] I_RX_PAUSE_VAL,
  // Transmit side handshake
  input  wire logic        I_TX_BUSY,
  input  wire logic        I_TX_PAUSE_ACK,
  input  wire logic        I_COL_DET,
  // Controls back to the framer
  output logic             O_TX_HOLD,
  output logic             O_TX_PAUSE_REQ,
  output logic      [15:0] O_TX_PAUSE_VAL,
  output logic             O_JAM,
  output logic             O_RX_CTRL_FWD,
  output logic             O_COL_EN,
  // Management pins
  output logic             O_MDC,
  output logic             O_MDIO_O,
  output logic             O_MDIO_OE,
  input  wire logic        I_MDIO_I
);
  import mpb_pkg::*;

  // All state lives in one packed struct: the comb block computes a
  // complete next copy and the clocked block registers it, so every
  // field shares the same reset and clock-enable treatment.

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [31:0] flow;
    logic [31:0] auto_cfg;
    logic [31:0] rdata;
    logic [15:0] pause_cnt;
    logic [15:0] tick_cnt;
    logic        pause_pend;
    logic [15:0] pause_pend_val;
    logic        tx_req;
    logic [15:0] tx_val;
    logic        fd_armed;
    logic        fd_sent_hi;
    mpb_bp_t     bp;
    logic [7:0]  dur_cnt;
    logic        fwd;
    logic [31:0] mg_shift;
    logic [7:0]  mg_cyc;
    logic [5:0]  mg_bits;
    logic        mg_busy;
    logic        mg_rd;
    logic [15:0] mg_rdata;
  } mpb_state_t;

  // Field groups: registers (flow, auto_cfg, rdata), received pause
  // (pause_cnt, tick_cnt, pending), pause generation (tx_req, tx_val,
  // fd_armed, fd_sent_hi), back pressure (bp, dur_cnt), forward pulse
  // and the management shifter (mg_*).

  mpb_state_t st_reg;
  mpb_state_t st_next;

  // Decoded views of the configuration registers
  logic        en;
  logic        fdx;
  logic [7:0]  lo_mark;
  logic [7:0]  hi_mark;
  logic [7:0]  dur_lim;
  logic        forced;
  logic        above_hi;
  logic        below_lo;
  logic        qual_hit;
  logic [15:0] q_cyc;

  // Threshold compare shared by both duplex paths
  // Unsigned; a fill equal to the mark counts as reaching it
  function automatic logic mpb_ge(input logic [7:0] a, input logic [7:0] b);
    mpb_ge = (a >= b);
  endfunction : mpb_ge

  // ----------------------------------------------------------------
  // Decoded configuration
  // ----------------------------------------------------------------
  assign en       = st_reg.flow[MPB_FLOW_EN_BIT];
  assign fdx      = st_reg.flow[MPB_FLOW_FD_BIT];
  assign lo_mark  = st_reg.auto_cfg[MPB_AUTO_LO_LSB +: 8];
  assign hi_mark  = st_reg.auto_cfg[MPB_AUTO_HI_LSB +: 8];
  assign dur_lim  = st_reg.auto_cfg[MPB_AUTO_DUR_LSB +: 8];
  // Forced mode: software steers jamming through the qualifiers alone
  assign forced   = (lo_mark == 8'hFF) && (hi_mark == 8'h00);
  assign above_hi = forced || mpb_ge(I_RX_FILL, hi_mark);
  assign below_lo = !forced && !mpb_ge(I_RX_FILL, lo_mark);
  assign qual_hit = st_reg.auto_cfg[MPB_AUTO_ANY_BIT]
                 || (st_reg.auto_cfg[MPB_AUTO_ADD_BIT] && I_RX_ADDR_MATCH)
                 || (st_reg.auto_cfg[MPB_AUTO_MUL_BIT] && I_RX_MCAST)
                 || (st_reg.auto_cfg[MPB_AUTO_BRD_BIT] && I_RX_BCAST);
  // Quantum length follows the active line rate
  assign q_cyc    = st_reg.flow[MPB_FLOW_SPD_BIT] ? MPB_Q_CYC_100 : MPB_Q_CYC_10;
  // Limitation: a speed change while a pause runs also alters the quantum
  // already counting, since tick_cnt is compared with the new q_cyc.

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    st_next       = st_reg;
    st_next.fwd   = 1'b0;
    st_next.rdata = 32'h0000_0000;

    // Defaults: pulses drop unless set again below, and read data are
    // zero outside the cycle after a read.

    // Register writes; a management write while busy is ignored so a
    // frame in flight is never corrupted
    if (I_WR) begin
      unique case (I_ADDR)
        MPB_ADDR_FLOW: st_next.flow = I_WDATA;
        MPB_ADDR_AUTO: st_next.auto_cfg = I_WDATA;
        MPB_ADDR_MGMT: begin
          if (!st_reg.mg_busy) begin
            st_next.mg_shift = I_WDATA;
            st_next.mg_busy  = 1'b1;
            st_next.mg_rd    = I_WDATA[29];
            st_next.mg_bits  = MPB_MG_BITS;
            st_next.mg_cyc   = MPB_MG_CYC;
          end
        end
        default: ;
      endcase
    end


    // Register reads, data one cycle later; unmapped reads return zero
    if (I_RD) begin
      unique case (I_ADDR)
        MPB_ADDR_FLOW:   st_next.rdata = st_reg.flow;
        MPB_ADDR_AUTO:   st_next.rdata = st_reg.auto_cfg;
        MPB_ADDR_STATUS: st_next.rdata = {st_reg.pause_cnt, 8'h00, st_reg.mg_busy,
                                          st_reg.fd_armed, st_reg.tx_req, (st_reg.pause_cnt != 16'h0000),
                                          st_reg.bp, 2'b00};
        MPB_ADDR_MGMT:   st_next.rdata = {31'h0000_0000, st_reg.mg_busy};
        MPB_ADDR_MGDATA: st_next.rdata = {16'h0000, st_reg.mg_rdata};
        default:         st_next.rdata = 32'h0000_0000;
      endcase
    end


    // Priority: a new pause frame beats a pending load, which beats the
    // quantum countdown. A zero value cancels both hold and pending.
    // Received pause: control frames also pass on to the receive path
    if (I_RX_PAUSE_VLD) begin
      st_next.fwd = 1'b1;
      if (en && fdx) begin
        if (I_RX_PAUSE_VAL == 16'h0000) begin
          st_next.pause_cnt  = 16'h0000;
          st_next.pause_pend = 1'b0;
        end else if (I_TX_BUSY) begin
          st_next.pause_pend     = 1'b1;
          st_next.pause_pend_val = I_RX_PAUSE_VAL;
        end else begin
          st_next.pause_cnt = I_RX_PAUSE_VAL;
          st_next.tick_cnt  = 16'h0000;
        end
      end
    end else if (st_reg.pause_pend && !I_TX_BUSY) begin
      st_next.pause_cnt  = st_reg.pause_pend_val;
      st_next.pause_pend = 1'b0;
      st_next.tick_cnt   = 16'h0000;
    end else if (st_reg.pause_cnt != 16'h0000) begin
      // One decrement per slot-time quantum
      if (st_reg.tick_cnt >= q_cyc - 16'h0001) begin
        st_next.tick_cnt  = 16'h0000;
        st_next.pause_cnt = st_reg.pause_cnt - 16'h0001;
      end else begin
        st_next.tick_cnt = st_reg.tick_cnt + 16'h0001;
      end
    end

    // Leaving full duplex or disabling flow control drops any hold at once
    if (!en || !fdx) begin
      st_next.pause_cnt  = 16'h0000;
      st_next.pause_pend = 1'b0;
    end


    // fd_armed and fd_sent_hi form the low-then-high rearm latch: only one
    // nonzero frame goes out per excursion above the high mark.
    // Full-duplex pause generation, one request held until the transmitter takes it
    if (st_reg.tx_req && I_TX_PAUSE_ACK) begin
      st_next.tx_req = 1'b0;
    end
    if (en && fdx) begin
      if (st_reg.fd_armed && above_hi) begin
        st_next.tx_req     = 1'b1;
        st_next.tx_val     = st_reg.flow[MPB_FLOW_PT_LSB +: 16];
        st_next.fd_armed   = 1'b0;
        st_next.fd_sent_hi = 1'b1;
      end else if (st_reg.fd_sent_hi && below_lo) begin
        st_next.tx_req     = 1'b1;
        st_next.tx_val     = 16'h0000;
        st_next.fd_sent_hi = 1'b0;
        st_next.fd_armed   = 1'b1;
      end
    end else begin
      st_next.fd_armed   = 1'b1;
      st_next.fd_sent_hi = 1'b0;
      st_next.tx_req     = 1'b0;
    end


    // The duration timer runs only while a frame is jammed and saturates at
    // the limit; it is cleared on every return to idle and after the one
    // frame that is let through, so a stale count never carries over.
    // Half-duplex back pressure
    if (st_reg.bp == MPB_BP_JAM && st_reg.dur_cnt != dur_lim) begin
      st_next.dur_cnt = st_reg.dur_cnt + 8'h01;
    end
    if (!en || fdx) begin
      st_next.bp      = MPB_BP_IDLE;
      st_next.dur_cnt = 8'h00;
    end else begin
      unique case (st_reg.bp)
        // Idle until the fill reaches the high mark
        MPB_BP_IDLE: begin
          if (above_hi) begin
            st_next.bp      = MPB_BP_WAIT;
            st_next.dur_cnt = 8'h00;
          end
        end

        // Armed: jam only a qualified frame start with the transmitter idle
        MPB_BP_WAIT: begin
          if (below_lo) begin
            st_next.bp      = MPB_BP_IDLE;
            st_next.dur_cnt = 8'h00;
          end else if (st_reg.dur_cnt == dur_lim) begin
            st_next.bp = MPB_BP_PASS;
          end else if (I_RX_SOF && !I_TX_BUSY && qual_hit) begin
            st_next.bp = MPB_BP_JAM;
          end
        end

        // Jam until the frame ends or the fill falls below the low mark
        MPB_BP_JAM: begin
          if (below_lo) begin
            st_next.bp      = MPB_BP_IDLE;
            st_next.dur_cnt = 8'h00;
          end else if (I_RX_EOF) begin
            st_next.bp = (st_next.dur_cnt == dur_lim) ? MPB_BP_PASS : MPB_BP_WAIT;
          end
        end

        // One frame passes unjammed; its end decides rearm or idle
        MPB_BP_PASS: begin
          if (I_RX_EOF) begin
            st_next.dur_cnt = 8'h00;
            st_next.bp      = below_lo ? MPB_BP_IDLE : MPB_BP_WAIT;
          end
        end
      endcase
    end


    // Each bit takes MPB_MG_CYC+1 clocks: the clock pin is low for the
    // first half and high for the second, and data change only at the
    // wrap, so the phy sees stable data on its rising edge. On reads the
    // line is released from the turnaround on and the last 16 bits are kept.
    // Management serial engine: shifts a 32-bit frame, captures low 16 on reads
    if (st_reg.mg_busy) begin
      if (st_reg.mg_cyc != 8'h00) begin
        st_next.mg_cyc = st_reg.mg_cyc - 8'h01;
      end else begin
        st_next.mg_cyc   = MPB_MG_CYC;
        st_next.mg_shift = {st_reg.mg_shift[30:0], 1'b0};
        if (st_reg.mg_rd && st_reg.mg_bits <= 6'h10) begin
          st_next.mg_rdata = {st_reg.mg_rdata[14:0], I_MDIO_I};
        end
        if (st_reg.mg_bits == 6'h01) begin
          st_next.mg_busy = 1'b0;
        end
        st_next.mg_bits = st_reg.mg_bits - 6'h01;
      end
    end
  end

  // ----------------------------------------------------------------
  // Registered state, frozen while the clock enable is low
  // Reset is synchronous and loads constants only, so it needs no
  // next-state logic and cannot pick up a stale input.
  // ----------------------------------------------------------------
  always_ff @(posedge I_SYS_CLK) begin
    if (!I_RST_N) begin
      st_reg            <= '0;
      st_reg.flow       <= MPB_FLOW_RST;
      st_reg.auto_cfg   <= MPB_AUTO_RST;
      st_reg.fd_armed   <= 1'b1;
      st_reg.bp         <= MPB_BP_IDLE;
    end else if (I_CE) begin
      st_reg <= st_next;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Handshake outputs are plain decodes of registered state
  assign O_RDATA        = st_reg.rdata;
  // Hold covers data frames only; pause frames still go out
  assign O_TX_HOLD      = (st_reg.pause_cnt != 16'h0000);
  assign O_TX_PAUSE_REQ = st_reg.tx_req;
  assign O_TX_PAUSE_VAL = st_reg.tx_val;
  assign O_JAM          = (st_reg.bp == MPB_BP_JAM);
  assign O_RX_CTRL_FWD  = st_reg.fwd;
  // No contention in full duplex; gaps and rate are left to the framer
  assign O_COL_EN       = !fdx;
  // Management clock only runs while a frame is in flight; the enable
  // drops for the turnaround and data phase of a read
  assign O_MDC          = st_reg.mg_busy && (st_reg.mg_cyc < (MPB_MG_CYC >> 1));
  assign O_MDIO_O       = st_reg.mg_shift[31];
  assign O_MDIO_OE      = st_reg.mg_busy && !(st_reg.mg_rd && st_reg.mg_bits <= 6'h12);


  // Unused: collision sensing stays with the framer, which also owns
  // gap timing and retransmission in half duplex.

endmodule : mpb_flow
`default_nettype wire

/* mpb_flow_props.sv */
`timescale 1ns/10ps
`default_nettype none
module mpb_flow_props (
  input wire logic        I_SYS_CLK,
  input wire logic        I_RST_N,
  input wire logic        I_CE,
  input wire logic [7:0]  I_ADDR,
  input wire logic [31:0] I_WDATA,
  input wire logic        I_WR,
  input wire logic        I_RX_SOF,
  input wire logic        I_RX_PAUSE_VLD,
  input wire logic [15:0] I_RX_PAUSE_VAL,
  input wire logic        I_TX_BUSY,
  input wire logic        I_TX_PAUSE_ACK,
  input wire logic        O_TX_HOLD,
  input wire logic        O_TX_PAUSE_REQ,
  input wire logic [15:0] O_TX_PAUSE_VAL,
  input wire logic        O_JAM,
  input wire logic        O_RX_CTRL_FWD,
  input wire logic        O_COL_EN
);
  import mpb_pkg::*;
  logic en_reg;
  logic fdx_reg;
  // Shadow of enable and duplex, so checks do not trust the design's own copy
  always_ff @(posedge I_SYS_CLK) begin
    if (!I_RST_N) begin
      en_reg  <= 1'b0;
      fdx_reg <= 1'b0;
    end else if (I_CE && I_WR && (I_ADDR == MPB_ADDR_FLOW)) begin
      en_reg  <= I_WDATA[MPB_FLOW_EN_BIT];
      fdx_reg <= I_WDATA[MPB_FLOW_FD_BIT];
    end
  end
  default clocking cb @(posedge I_SYS_CLK);
  endclocking
  default disable iff (!I_RST_N);
  // ----------------------------------------------------------------
  // Properties; jam and hold may trail their cause by one register
  // ----------------------------------------------------------------
  AST_COL_EN: assert property (O_COL_EN == !fdx_reg)
    else $error("collision enable does not follow duplex");
  AST_JAM_EN: assert property ($rose(O_JAM) |-> en_reg && !fdx_reg)
    else $error("jam without enable or in full duplex");
  AST_REQ_EN: assert property ($rose(O_TX_PAUSE_REQ) |-> en_reg && fdx_reg)
    else $error("pause request without enable or in half duplex");
  AST_JAM_SOF: assert property ($rose(O_JAM) |-> ($past(I_RX_SOF) && !$past(I_TX_BUSY))
    || ($past(I_RX_SOF, 2) && !$past(I_TX_BUSY, 2))) else $error("jam not at an idle frame start");
  AST_REQ_HOLD: assert property (O_TX_PAUSE_REQ && !I_TX_PAUSE_ACK |=>
    O_TX_PAUSE_REQ && $stable(O_TX_PAUSE_VAL)) else $error("pause request dropped before ack");
  AST_FWD: assert property (I_CE && I_RX_PAUSE_VLD |=> O_RX_CTRL_FWD)
    else $error("control frame not forwarded");
  AST_FWD_CAUSE: assert property (O_RX_CTRL_FWD |-> $past(I_RX_PAUSE_VLD))
    else $error("forward pulse without control frame");
  AST_HOLD_LOAD: assert property (I_RX_PAUSE_VLD && (I_RX_PAUSE_VAL != 16'h0000) && en_reg && fdx_reg
    && !I_TX_BUSY |-> ##[1:2] O_TX_HOLD) else $error("pause frame did not hold transmit");
  AST_HOLD_ZERO: assert property (I_RX_PAUSE_VLD && (I_RX_PAUSE_VAL == 16'h0000) && en_reg && fdx_reg
    && !I_TX_BUSY |-> ##[1:2] !O_TX_HOLD) else $error("zero pause did not end hold");
  AST_HOLD_TX: assert property ($rose(O_TX_HOLD) |-> !$past(I_TX_BUSY))
    else $error("hold began during a transmission");
endmodule : mpb_flow_props
bind mpb_flow mpb_flow_props u_props (.I_SYS_CLK(I_SYS_CLK), .I_RST_N(I_RST_N), .I_CE(I_CE),
  .I_ADDR(I_ADDR), .I_WDATA(I_WDATA), .I_WR(I_WR), .I_RX_SOF(I_RX_SOF), .I_RX_PAUSE_VLD(I_RX_PAUSE_VLD),
  .I_RX_PAUSE_VAL(I_RX_PAUSE_VAL), .I_TX_BUSY(I_TX_BUSY), .I_TX_PAUSE_ACK(I_TX_PAUSE_ACK),
  .O_TX_HOLD(O_TX_HOLD), .O_TX_PAUSE_REQ(O_TX_PAUSE_REQ), .O_TX_PAUSE_VAL(O_TX_PAUSE_VAL),
  .O_JAM(O_JAM), .O_RX_CTRL_FWD(O_RX_CTRL_FWD), .O_COL_EN(O_COL_EN));
`default_nettype wire

/* mpb_pkg.sv */
package mpb_pkg;
  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0]  MPB_ADDR_FLOW    = 8'h00; // Enable and pause time
  localparam logic [7:0]  MPB_ADDR_AUTO    = 8'h04; // Marks, duration, qualifiers
  localparam logic [7:0]  MPB_ADDR_STATUS  = 8'h08; // Live state, read only
  localparam logic [7:0]  MPB_ADDR_MGMT    = 8'h0C; // Indirect phy register access
  localparam logic [7:0]  MPB_ADDR_MGDATA  = 8'h10; // Management read data
  // Field positions
  localparam int          MPB_FLOW_EN_BIT  = 0;
  localparam int          MPB_FLOW_FD_BIT  = 1;
  localparam int          MPB_FLOW_SPD_BIT = 2;
  localparam int          MPB_FLOW_PT_LSB  = 16;
  localparam int          MPB_AUTO_LO_LSB  = 0;
  localparam int          MPB_AUTO_HI_LSB  = 8;
  localparam int          MPB_AUTO_DUR_LSB = 16;
  localparam int          MPB_AUTO_ANY_BIT = 24;
  localparam int          MPB_AUTO_ADD_BIT = 25;
  localparam int          MPB_AUTO_MUL_BIT = 26;
  localparam int          MPB_AUTO_BRD_BIT = 27;
  // Reset values
  localparam logic [31:0] MPB_FLOW_RST     = 32'h0000_0000;
  localparam logic [31:0] MPB_AUTO_RST     = 32'h0000_0000;
  // Timing: one quantum is 512 bit times
  localparam int          MPB_QUANTUM_BITS = 512;
  localparam int          MPB_CLK_MHZ      = 250;
  localparam int          MPB_BIT_NS_100   = 10;
  localparam int          MPB_BIT_NS_10    = 100;
  localparam int          MPB_CLK_NS       = 1000 / MPB_CLK_MHZ;
  localparam logic [15:0] MPB_Q_CYC_100    = 16'((MPB_QUANTUM_BITS * MPB_BIT_NS_100) / MPB_CLK_NS);
  localparam logic [15:0] MPB_Q_CYC_10     = 16'((MPB_QUANTUM_BITS * MPB_BIT_NS_10) / MPB_CLK_NS);
  // Management bit length in clock cycles less one, and frame length in bits
  localparam logic [7:0]  MPB_MG_CYC       = 8'h40;
  localparam logic [5:0]  MPB_MG_BITS      = 6'h20;

  typedef enum logic [1:0] {
    MPB_BP_IDLE = 2'b00,   // Below marks, no back pressure
    MPB_BP_WAIT = 2'b01,   // Armed, waiting for a receive start
    MPB_BP_JAM  = 2'b11,   // Jamming a received frame
    MPB_BP_PASS = 2'b10    // Duration elapsed, letting one frame in
  } mpb_bp_t;
endpackage : mpb_pkg

/* mpb_station.sv */
`timescale 1ns/10ps
`default_nettype none
module mpb_station #(
  parameter int ACK_DLY = 5
) (
  input  wire logic        i_sys_clk,
  input  wire logic        i_rst_n,
  input  wire logic        i_req,
  input  wire logic [15:0] i_val,
  output logic             o_ack,
  output logic      [7:0]  o_cnt,
  output logic      [15:0] o_last,
  input  wire logic        i_mdc,
  input  wire logic        i_mdio_o,
  input  wire logic        i_mdio_oe,
  output logic             o_mdio_i,
  output logic      [31:0] o_cap
);
  int   wait_cnt;
  logic mdc_reg;
  // Pull-up on the management line; this phy never drives, so reads see ones
  assign o_mdio_i = i_mdio_oe ? i_mdio_o : 1'b1;
  // Transmitter takes a pause request after a delay and logs what it sent
  always_ff @(posedge i_sys_clk) begin
    o_ack   <= 1'b0;
    mdc_reg <= i_mdc;
    if (!i_rst_n) begin
      wait_cnt <= 0;
      o_cnt    <= 8'h00;
      o_last   <= 16'h0000;
      o_cap    <= 32'h0000_0000;
    end else begin
      if (i_req && !o_ack) begin
        wait_cnt <= (wait_cnt == ACK_DLY) ? 0 : wait_cnt + 1;
      end
      if (i_req && !o_ack && (wait_cnt == ACK_DLY)) begin
        o_ack  <= 1'b1;
        o_cnt  <= o_cnt + 8'h01;
        o_last <= i_val;
      end
      // Phy samples on the clock's rising edge, MSB first
      if (i_mdc && !mdc_reg && i_mdio_oe) begin
        o_cap <= {o_cap[30:0], i_mdio_o};
      end
    end
  end
endmodule : mpb_station
`default_nettype wire

/* tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import mpb_pkg::*;
  localparam int TMO = 40000;
  logic        i_sys_clk, i_rst_n, i_wr, i_rd, i_rx_sof, i_rx_eof, i_am, i_mc, i_bc, i_pvld, i_tx_busy;
  logic        o_hold, o_req, o_jam, o_fwd, o_col_en, o_mdc, o_mdo, o_mdoe, mdio_i, ack;
  logic [7:0]  i_addr, i_rx_fill, cnt;
  logic [15:0] i_pval, o_pval, last;
  logic [31:0] i_wdata, o_rdata, cap, d;
  int          errors, tests_run, cyc;
  mpb_flow u_dut (.I_SYS_CLK(i_sys_clk), .I_RST_N(i_rst_n), .I_CE(1'b1), .I_ADDR(i_addr), .I_WDATA(i_wdata),
    .I_WR(i_wr), .I_RD(i_rd), .O_RDATA(o_rdata), .I_RX_FILL(i_rx_fill), .I_RX_SOF(i_rx_sof), .I_RX_EOF(i_rx_eof),
    .I_RX_ADDR_MATCH(i_am), .I_RX_MCAST(i_mc), .I_RX_BCAST(i_bc), .I_RX_PAUSE_VLD(i_pvld), .I_RX_PAUSE_VAL(i_pval),
    .I_TX_BUSY(i_tx_busy), .I_TX_PAUSE_ACK(ack), .I_COL_DET(1'b0), .O_TX_HOLD(o_hold), .O_TX_PAUSE_REQ(o_req),
    .O_TX_PAUSE_VAL(o_pval), .O_JAM(o_jam), .O_RX_CTRL_FWD(o_fwd), .O_COL_EN(o_col_en), .O_MDC(o_mdc),
    .O_MDIO_O(o_mdo), .O_MDIO_OE(o_mdoe), .I_MDIO_I(mdio_i));
  mpb_station u_station (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_req(o_req), .i_val(o_pval), .o_ack(ack),
    .o_cnt(cnt), .o_last(last), .i_mdc(o_mdc), .i_mdio_o(o_mdo), .i_mdio_oe(o_mdoe), .o_mdio_i(mdio_i), .o_cap(cap));
  // ----------------------------------------------------------------
  // Bus and line tasks; each returns just after a rising edge
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge i_sys_clk);
    #1;
  endtask : tick
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge i_sys_clk);
    i_wr    <= 1'b1;
    i_addr  <= a;
    i_wdata <= v;
    tick(1);
    i_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge i_sys_clk);
    i_rd   <= 1'b1;
    i_addr <= a;
    tick(1);
    i_rd <= 1'b0;
    d    = o_rdata;
  endtask : rd
  task automatic rx(input logic s, input logic e, input logic [2:0] q);
    @(posedge i_sys_clk);
    i_rx_sof        <= s;
    i_rx_eof        <= e;
    {i_bc, i_mc, i_am} <= q;
    tick(1);
    i_rx_sof <= 1'b0;
    i_rx_eof <= 1'b0;
    tick(1);
  endtask : rx
  task automatic pv(input logic [15:0] v);
    @(posedge i_sys_clk);
    i_pvld <= 1'b1;
    i_pval <= v;
    tick(1);
    i_pvld <= 1'b0;
  endtask : pv
  task automatic set(input logic [7:0] f, input logic b);
    @(posedge i_sys_clk);
    i_rx_fill <= f;
    i_tx_busy <= b;
    tick(1);
  endtask : set
  task automatic mg(input logic [31:0] f);
    wr(MPB_ADDR_MGMT, f);
    rd(MPB_ADDR_MGMT);
    chk("mg_busy", 32'h1, 32'(d[0]));
    repeat (100) begin
      tick(40);
      rd(MPB_ADDR_MGMT);
      if (d[0] === 1'b0) break;
    end
    chk("mg_idle", 32'h0, 32'(d[0]));
  endtask : mg
  task automatic results;
    $display("comparisons %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : results
  // Free-running clock and a hang guard
  initial begin
    i_sys_clk = 1'b0;
    forever #2 i_sys_clk = ~i_sys_clk;
  end
  always @(posedge i_sys_clk) begin
    cyc++;
    if (cyc == TMO) begin
      errors++;
      $display("BAD timeout expected done seen hang");
      results();
    end
  end
  // Main sequence: reset, then full duplex, pause hold, back pressure, management
  initial begin
    {i_rst_n, i_wr, i_rd, i_rx_sof, i_rx_eof, i_am, i_mc, i_bc, i_pvld, i_tx_busy} = 10'h000;
    {i_addr, i_rx_fill, i_pval, i_wdata} = 64'h0;
    repeat (4) @(posedge i_sys_clk);
    i_rst_n <= 1'b1;
    rd(MPB_ADDR_FLOW);
    chk("flow_rst", MPB_FLOW_RST, d);
    rd(MPB_ADDR_AUTO);
    chk("auto_rst", MPB_AUTO_RST, d);
    wr(8'h20, 32'hFFFF_FFFF);
    rd(8'h20);
    chk("unmapped", 32'h0, d);
    chk("col_en", 32'h1, 32'(o_col_en));
    wr(MPB_ADDR_AUTO, 32'h01FF_4010);
    wr(MPB_ADDR_FLOW, 32'h1234_0002);
    set(8'h40, 1'b0);
    tick(20);
    chk("req_off", 32'h0, 32'(cnt));
    wr(MPB_ADDR_FLOW, 32'h1234_0000);
    rx(1'b1, 1'b0, 3'h0);
    chk("jam_off", 32'h0, 32'(o_jam));
    $display("disabled test finished");
    wr(MPB_ADDR_FLOW, 32'h1234_0007);
    tick(20);
    chk("pause_cnt", 32'h1, 32'(cnt));
    chk("pause_val", 32'h1234, 32'(last));
    chk("col_fd", 32'h0, 32'(o_col_en));
    set(8'h30, 1'b0);
    set(8'h40, 1'b0);
    tick(20);
    chk("no_rearm", 32'h1, 32'(cnt));
    set(8'h0F, 1'b0);
    tick(20);
    chk("zero_cnt", 32'h2, 32'(cnt));
    chk("zero_val", 32'h0, 32'(last));
    set(8'h40, 1'b0);
    tick(20);
    chk("rearm", 32'h3, 32'(cnt));
    $display("pause send test finished");
    set(8'h40, 1'b1);
    pv(16'h0003);
    chk("fwd", 32'h1, 32'(o_fwd));
    tick(4);
    chk("hold_busy", 32'h0, 32'(o_hold));
    set(8'h40, 1'b0);
    tick(2);
    chk("hold_after", 32'h1, 32'(o_hold));
    pv(16'h0000);
    tick(1);
    chk("hold_zero", 32'h0, 32'(o_hold));
    pv(16'h0002);
    tick(1270);
    chk("hold_q100", 32'h1, 32'(o_hold));
    tick(1300);
    chk("hold_end", 32'h0, 32'(o_hold));
    wr(MPB_ADDR_FLOW, 32'h1234_0003);
    pv(16'h0002);
    tick(12700);
    chk("hold_q10", 32'h1, 32'(o_hold));
    pv(16'h0000);
    tick(1);
    chk("hold_zero10", 32'h0, 32'(o_hold));
    $display("pause obey test finished");
    wr(MPB_ADDR_FLOW, 32'h0000_0005);
    wr(MPB_ADDR_AUTO, 32'h0108_4010);
    set(8'h40, 1'b1);
    rx(1'b1, 1'b0, 3'h0);
    chk("jam_txbusy", 32'h0, 32'(o_jam));
    set(8'h40, 1'b0);
    rx(1'b1, 1'b0, 3'h0);
    chk("jam_on", 32'h1, 32'(o_jam));
    tick(10);
    rx(1'b0, 1'b1, 3'h0);
    rd(MPB_ADDR_STATUS);
    chk("bp_pass", 32'h2, 32'(d[3:2]));
    rx(1'b1, 1'b0, 3'h0);
    chk("jam_pass", 32'h0, 32'(o_jam));
    rx(1'b0, 1'b1, 3'h0);
    rd(MPB_ADDR_STATUS);
    chk("bp_rewait", 32'h1, 32'(d[3:2]));
    rx(1'b1, 1'b0, 3'h0);
    chk("jam_again", 32'h1, 32'(o_jam));
    set(8'h0F, 1'b0);
    tick(1);
    chk("jam_low", 32'h0, 32'(o_jam));
    rd(MPB_ADDR_STATUS);
    chk("bp_idle", 32'h0, 32'(d[3:2]));
    set(8'h20, 1'b0);
    rx(1'b1, 1'b0, 3'h0);
    chk("jam_disarm", 32'h0, 32'(o_jam));
    set(8'h40, 1'b0);
    for (int q = 1; q < 4; q++) begin
      wr(MPB_ADDR_AUTO, 32'h00FF_4010 | (32'h1 << (MPB_AUTO_ANY_BIT + q)));
      rx(1'b1, 1'b0, 3'(1 << (q % 3)));
      chk("jam_wrongq", 32'h0, 32'(o_jam));
      rx(1'b1, 1'b0, 3'(1 << (q - 1)));
      chk("jam_rightq", 32'h1, 32'(o_jam));
      rx(1'b0, 1'b1, 3'h0);
    end
    wr(MPB_ADDR_AUTO, 32'h01FF_00FF);
    set(8'h00, 1'b0);
    rx(1'b1, 1'b0, 3'h0);
    chk("jam_forced", 32'h1, 32'(o_jam));
    rx(1'b0, 1'b1, 3'h0);
    wr(MPB_ADDR_AUTO, 32'h00FF_00FF);
    rx(1'b1, 1'b0, 3'h0);
    chk("jam_swoff", 32'h0, 32'(o_jam));
    $display("back pressure test finished");
    mg(32'h5012_ABCD);
    chk("mg_frame", 32'h5012_ABCD, cap);
    mg(32'h6012_0000);
    rd(MPB_ADDR_MGDATA);
    chk("mg_data", 32'hFFFF, 32'(d[15:0]));
    $display("management test finished");
    results();
  end
endmodule : tb_top
`default_nettype wire
